/* File: rtl/pms_pkg.sv */
// constants for the power manager serial link slave
// Notes on behaviour
// - device is link slave; master drives clock, select
// - address from four straps, twelve devices 0-11
// - frame: select, address, count on reads, data
// - 8-bit register addresses, 16-bit data words
// - respond when bits 7:5 zero, 4:1 match straps
// - broadcast 001/0000 with write flag: all write
// - broadcast read has no effect, data invalid
// - data word travels high byte first
// - read data valid within 24 clocks; high-z before
// - miso released after select rises
// - core clocked from own oscillator, not link
package pms_pkg;
  localparam int          PMS_SYS_MHZ     = 125;         // core clock rate
  localparam int          PMS_ADDR_W      = 8;           // register address width
  localparam int          PMS_DATA_W      = 16;          // register data width
  localparam int          PMS_STRAP_W     = 4;           // strap pin count
  localparam logic [2:0]  PMS_SEL_UNICAST = 3'h0;        // select prefix, own device
  localparam logic [2:0]  PMS_SEL_BCAST   = 3'h1;        // select prefix, broadcast
  localparam logic [3:0]  PMS_BCAST_ADDR  = 4'h0;        // broadcast device field
  localparam logic [3:0]  PMS_MAX_DEV     = 4'hb;        // highest legal strap value
  localparam logic [2:0]  PMS_BIT_LAST    = 3'h7;        // last bit index of a byte
  localparam logic [1:0]  PMS_BYTE_SEL    = 2'h0;        // header byte indices
  localparam logic [1:0]  PMS_BYTE_ADDR   = 2'h1;
  localparam logic [1:0]  PMS_BYTE_CNT    = 2'h2;

  // frame phases, one-hot
  typedef enum logic [4:0] {
    PMS_IDLE   = 5'h01,   // waiting for select
    PMS_HDR    = 5'h02,   // receiving select, address, count
    PMS_WDATA  = 5'h04,   // receiving write words
    PMS_RDATA  = 5'h08,   // sending read words
    PMS_IGNORE = 5'h10    // not addressed, wait for select release
  } pms_state_t;
endpackage

/* File: rtl/pms_spi_slave.sv */
// serial link slave for the power manager register space
`timescale 1ns/1ps
module pms_spi_slave
  import pms_pkg::*;
#(
  parameter int ADDR_W = PMS_ADDR_W,
  parameter int DATA_W = PMS_DATA_W
)(
  input  wire logic              clk_sys,       // core clock, own oscillator
  input  wire logic              resetn,        // async reset, active low
  input  wire logic              sck,           // link clock from controller
  input  wire logic              cs_n,          // chip select, active low
  input  wire logic              mosi,          // serial data in
  output logic                   miso_o,        // serial data out
  output logic                   miso_oe,       // high while driving miso
  input  wire logic [3:0]        device_select_straps, // device address straps
  output logic                   wr_valid,      // one-cycle write strobe
  output logic [ADDR_W-1:0]      wr_addr,       // write register address
  output logic [DATA_W-1:0]      wr_data,       // write value
  output logic                   rd_req,        // one-cycle read request
  output logic [ADDR_W-1:0]      rd_addr,       // read register address
  input  wire logic [DATA_W-1:0] rd_data        // read value, valid cycle after rd_req
);
  // synchronisers for all link pins; core never runs on link clock
  logic [1:0] sck_s;
  logic [1:0] cs_s;
  logic [1:0] mosi_s;
  logic [3:0] strap_a;                     // strap first stage
  logic [3:0] strap_b;                     // strap second stage
  logic       sck_d;                       // previous synced clock
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sck_s   <= 2'h0;
      cs_s    <= 2'h3;
      mosi_s  <= 2'h0;
      strap_a <= 4'h0;
      strap_b <= 4'h0;
      sck_d   <= 1'b0;
    end
    else
    begin
      sck_s   <= {sck_s[0], sck};
      cs_s    <= {cs_s[0], cs_n};
      mosi_s  <= {mosi_s[0], mosi};
      strap_a <= device_select_straps;
      strap_b <= strap_a;
      sck_d   <= sck_s[1];
    end
  end

  // edge detect on the second stage only
  wire sck_rise = sck_s[1] & ~sck_d;
  wire sck_fall = ~sck_s[1] & sck_d;
  wire cs_act   = ~cs_s[1];
  wire mosi_b   = mosi_s[1];

  pms_state_t state;
  pms_state_t next_state;
  logic [2:0]        bit_cnt;              // bit index within byte
  logic [1:0]        hdr_idx;              // header byte number
  logic              byte_hi;              // data byte is the high one
  logic [7:0]        shin;                 // receive shift register
  logic [7:0]        hold_hi;              // received high data byte
  logic [ADDR_W-1:0] reg_addr;             // current register address
  logic [7:0]        words_left;           // read words remaining
  logic              is_write;             // frame direction
  logic [DATA_W-1:0] shout;                // transmit shift register
  logic              load_pend;            // read data valid this cycle
  logic              shift_ok;             // master has taken the bit now on miso

  // byte assembled msb first
  wire [7:0] byte_in   = {shin[6:0], mosi_b};
  wire       byte_done = sck_rise & (bit_cnt == PMS_BIT_LAST);
  // select decode: own address or write broadcast
  wire       own_hit   = (byte_in[7:5] == PMS_SEL_UNICAST) & (byte_in[4:1] == strap_b) &
                         (strap_b <= PMS_MAX_DEV);
  wire       bc_hit    = (byte_in[7:5] == PMS_SEL_BCAST) & (byte_in[4:1] == PMS_BCAST_ADDR) & byte_in[0];
  // broadcast read falls to ignore: no effect
  wire       sel_ok    = own_hit | bc_hit;

  // phase sequencing, select release aborts any phase
  always_comb
  begin
    next_state = state;
    case (state)
      PMS_IDLE:   if (cs_act) next_state = PMS_HDR;
      PMS_HDR:
        if (!cs_act) next_state = PMS_IDLE;
        else if (byte_done && hdr_idx == PMS_BYTE_SEL && !sel_ok) next_state = PMS_IGNORE;
        else if (byte_done && hdr_idx == PMS_BYTE_ADDR && is_write) next_state = PMS_WDATA;
        else if (byte_done && hdr_idx == PMS_BYTE_CNT) next_state = PMS_RDATA;
      PMS_WDATA:  if (!cs_act) next_state = PMS_IDLE;
      PMS_RDATA:  if (!cs_act) next_state = PMS_IDLE;
      PMS_IGNORE: if (!cs_act) next_state = PMS_IDLE;
      default:    next_state = PMS_IDLE;
    endcase
  end

  // bit and byte counting; reset each frame so gaps need no timing
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state   <= PMS_IDLE;
      bit_cnt <= 3'h0;
      hdr_idx <= 2'h0;
      byte_hi <= 1'b1;
      shin    <= 8'h00;
    end
    else
    begin
      state <= next_state;
      if (!cs_act)
      begin
        bit_cnt <= 3'h0;
        hdr_idx <= 2'h0;
        byte_hi <= 1'b1;
      end
      else if (sck_rise)
      begin
        shin    <= byte_in;
        bit_cnt <= bit_cnt + 3'h1;
        if (byte_done && state == PMS_HDR)
          hdr_idx <= hdr_idx + 2'h1;
        if (byte_done && (state == PMS_WDATA || state == PMS_RDATA))
          byte_hi <= ~byte_hi;              // high byte then low
      end
    end
  end

  // header fields and write assembly
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      is_write   <= 1'b0;
      reg_addr   <= '0;
      words_left <= 8'h00;
      hold_hi    <= 8'h00;
      wr_valid   <= 1'b0;
      wr_addr    <= '0;
      wr_data    <= '0;
    end
    else
    begin
      wr_valid <= 1'b0;
      if (byte_done && state == PMS_HDR)
      begin
        if (hdr_idx == PMS_BYTE_SEL)  is_write <= byte_in[0];
        if (hdr_idx == PMS_BYTE_ADDR) reg_addr <= byte_in[ADDR_W-1:0];
        if (hdr_idx == PMS_BYTE_CNT)  words_left <= byte_in;
      end
      else if (byte_done && state == PMS_WDATA)
      begin
        if (byte_hi)
          hold_hi <= byte_in;
        else
        begin
          wr_valid <= 1'b1;                 // own or broadcast write
          wr_addr  <= reg_addr;
          wr_data  <= {hold_hi, byte_in};
          reg_addr <= reg_addr + 1'b1;      // further words go to next address
        end
      end
      else if (byte_done && state == PMS_RDATA && !byte_hi && words_left != 8'h00)
      begin
        words_left <= words_left - 8'h01;
        if (words_left > 8'h01)
          reg_addr <= reg_addr + 1'b1;      // next read word comes from next address
      end
    end
  end

  // read fetch: first word at count byte, next at each word end except the last
  wire fetch = (byte_done && state == PMS_HDR && hdr_idx == PMS_BYTE_CNT) ||
               (byte_done && state == PMS_RDATA && !byte_hi && words_left > 8'h01);
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_req    <= 1'b0;
      rd_addr   <= '0;
      load_pend <= 1'b0;
    end
    else
    begin
      rd_req    <= fetch;
      load_pend <= rd_req;
      if (fetch)
        rd_addr <= (state == PMS_HDR) ? reg_addr : reg_addr + 1'b1;
    end
  end

  // miso drive: valid after count byte, well inside 24 clocks
  // shifts change on falling edges so master samples on rising
  // a fall shifts only once a rise has taken the current bit; the fall that
  // closes the count byte or a word would otherwise skip the fresh msb
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      shout    <= '0;
      miso_o   <= 1'b0;
      miso_oe  <= 1'b0;
      shift_ok <= 1'b0;
    end
    else if (state != PMS_RDATA || !cs_act)
    begin
      miso_oe  <= 1'b0;                     // released with select
      miso_o   <= 1'b0;
      shift_ok <= 1'b0;
    end
    else if (load_pend)
    begin
      shout    <= {rd_data[DATA_W-2:0], 1'b0};
      miso_o   <= rd_data[DATA_W-1];        // word msb first
      miso_oe  <= 1'b1;
      shift_ok <= 1'b0;                     // fresh word waits for its first rise
    end
    else if (sck_rise && miso_oe)
      shift_ok <= 1'b1;                     // master has taken this bit
    else if (sck_fall && shift_ok)
    begin
      miso_o   <= shout[DATA_W-1];
      shout    <= {shout[DATA_W-2:0], 1'b0};
      shift_ok <= 1'b0;
    end
  end

  // idle phase never leaves miso driven
  property p_miso_off_idle;
    @(posedge clk_sys) disable iff (!resetn)
    (state == PMS_IDLE) |=> !miso_oe;
  endproperty
  a_miso_off_idle: assert property (p_miso_off_idle) else $error("miso driven outside frame");

  // an ignored frame neither drives nor writes
  property p_ignore_quiet;
    @(posedge clk_sys) disable iff (!resetn)
    (state == PMS_IGNORE) |-> (!miso_oe && !wr_valid);
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet) else $error("ignored frame acted");

  // read data reaches the line two cycles after the request
  property p_rd_to_drive;
    @(posedge clk_sys) disable iff (!resetn)
    (rd_req && state == PMS_RDATA && cs_act) ##1 cs_act |=> miso_oe;
  endproperty
  a_rd_to_drive: assert property (p_rd_to_drive) else $error("miso late");

  // writes only come out of the data phase
  property p_wr_only_wdata;
    @(posedge clk_sys) disable iff (!resetn)
    wr_valid |-> $past(state == PMS_WDATA);
  endproperty
  a_wr_only_wdata: assert property (p_wr_only_wdata) else $error("write outside data phase");

  // a write needs its low byte
  property p_wr_pair;
    @(posedge clk_sys) disable iff (!resetn)
    wr_valid |-> $past(byte_hi == 1'b0);
  endproperty
  a_wr_pair: assert property (p_wr_pair) else $error("write before low byte");

  // unmatched select, broadcast read included, lands in ignore
  property p_bcast_read;
    @(posedge clk_sys) disable iff (!resetn)
    (byte_done && state == PMS_HDR && hdr_idx == PMS_BYTE_SEL && bc_hit == 1'b0 && !own_hit)
    |=> (state == PMS_IGNORE || !cs_act);
  endproperty
  a_bcast_read: assert property (p_bcast_read) else $error("unselected frame accepted");

  // own select with a legal strap value keeps the header going
  property p_sel_match;
    @(posedge clk_sys) disable iff (!resetn)
    (byte_done && cs_act && state == PMS_HDR && hdr_idx == PMS_BYTE_SEL &&
     byte_in[7:5] == PMS_SEL_UNICAST && byte_in[4:1] == strap_b && strap_b <= PMS_MAX_DEV)
    |=> (state == PMS_HDR);
  endproperty
  a_sel_match: assert property (p_sel_match) else $error("select decode");

  // write frames leave miso released
  property p_no_drive_write;
    @(posedge clk_sys) disable iff (!resetn)
    (state == PMS_WDATA) |-> !miso_oe;
  endproperty
  a_no_drive_write: assert property (p_no_drive_write) else $error("miso driven on write");
endmodule

/* File: verif/pms_master_model.sv */
// controller-side model that drives the link as its master
`timescale 1ns/1ps
module pms_master_model
#(
  parameter int HALF_NS = 80           // half link period, 160 ns link clock
)(
  output logic      sck,               // link clock, still outside frames
  output logic      cs_n,              // chip select, active low
  output logic      mosi,              // serial data toward the slave
  input  wire logic miso               // serial data back from the slave
);
  // idle levels before the first frame
  initial
  begin
    sck  = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // select low, then one link period of lead time
  task automatic open_frame;
    cs_n = 1'b0;
    #(2*HALF_NS);
  endtask

  // one byte each way; the caller keeps frame order
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      mosi = tx[i];                    // msb first
      #(HALF_NS);
      sck = 1'b1;
      rx[i] = miso;                    // captured on the rising edge
      #(HALF_NS);
      sck = 1'b0;
    end
    #(2*HALF_NS);                      // one idle link period between bytes
  endtask

  // release select; mosi flips so a stale level is never mistaken for data
  task automatic close_frame;
    cs_n = 1'b1;
    mosi = ~mosi;
    #(4*HALF_NS);                      // gap between frames
  endtask
endmodule

/* File: verif/pms_spi_slave_tb.sv */
// self-checking bench for the link slave
`timescale 1ns/1ps
module pms_spi_slave_tb;
  import pms_pkg::*;
  logic        clk_sys;                // core clock
  logic        resetn;                 // async reset, active low
  logic        sck;                    // link clock from model
  logic        cs_n;                   // chip select from model
  logic        mosi;                   // data from model
  logic        miso_o;                 // slave data out
  logic        miso_oe;                // slave output enable
  logic        wr_valid;               // write strobe
  logic        rd_req;                 // read strobe
  logic [3:0]  straps;                 // device address straps
  logic [7:0]  wr_addr;                // write address seen
  logic [7:0]  rd_addr;                // read address seen
  logic [15:0] wr_data;                // write value seen
  logic [15:0] rd_data;                // register file answer
  logic [23:0] wq[$];                  // captured writes, address and data
  int          nrd;                    // read strobes seen
  int          oe_hits;                // cycles with miso driven
  int          mismatches;             // failed comparisons
  int          checks;                 // comparisons made
  wire         miso = miso_oe ? miso_o : 1'bz;  // no pull on the shared line

  pms_spi_slave pms_spi_slave_i (.clk_sys(clk_sys), .resetn(resetn), .sck(sck), .cs_n(cs_n), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe), .device_select_straps(straps), .wr_valid(wr_valid), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data));
  pms_master_model m (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  // 125 MHz core clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // watch the user side; a pulse is only visible at one edge
  always @(posedge clk_sys)
  begin
    if (wr_valid === 1'b1) wq.push_back({wr_addr, wr_data});
    if (rd_req === 1'b1) nrd++;
    if (miso_oe === 1'b1) oe_hits++;
  end

  // register file answers the cycle after the request
  always @(negedge clk_sys)
    if (rd_req === 1'b1) rd_data <= {rd_addr, ~rd_addr};

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic send(input logic [7:0] b);
    logic [7:0] rx;
    m.xfer(b, rx);
  endtask

  // two words to own address, then a broadcast write
  task automatic write_cases;
    m.open_frame();
    send({3'h0, straps, 1'b1});
    send(8'hff);
    send(8'ha5); send(8'h5a); send(8'h0f); send(8'hf0);
    m.close_frame();
    m.open_frame();
    send({PMS_SEL_BCAST, PMS_BCAST_ADDR, 1'b1});
    send(8'h3c); send(8'h80); send(8'h01);
    m.close_frame();
    check(wq.size(), 3);
    check(wq[0], {8'hff, 16'ha55a});
    check(wq[1], {8'h00, 16'h0ff0});                      // address wraps to the next word
    check(wq[2], {8'h3c, 16'h8001});
  endtask

  // three-word read; line stays released until the count is in
  task automatic read_case;
    logic [7:0] hi;
    logic [7:0] lo;
    oe_hits = 0;
    m.open_frame();
    send({3'h0, straps, 1'b0});
    send(8'h80);
    check(oe_hits, 0);
    send(8'h03);
    for (int w = 0; w < 3; w++)
    begin
      m.xfer(8'h00, hi);
      m.xfer(8'h00, lo);
      check({hi, lo}, {8'h80 + w[7:0], ~(8'h80 + w[7:0])});
    end
    m.close_frame();
    check(nrd, 3);
    check(miso_oe, 1'b0);
  endtask

  // foreign, malformed and broadcast-read selects do nothing
  task automatic ignore_cases;
    logic [7:0] sel[4] = '{8'h15, 8'h57, 8'h20, 8'h23};
    wq.delete();
    nrd = 0;
    oe_hits = 0;
    foreach (sel[i])
    begin
      m.open_frame();
      send(sel[i]);
      send(8'h10); send(8'h01); send(8'hab); send(8'hcd);
      m.close_frame();
    end
    straps = 4'hc;                                        // strap value above the legal range
    m.open_frame();
    send({3'h0, straps, 1'b1});
    send(8'h10);
    send(8'hab);
    send(8'hcd);
    m.close_frame();
    straps = PMS_MAX_DEV;
    check(wq.size(), 0);
    check(nrd, 0);
    check(oe_hits, 0);
  endtask

  // main sequence: reset, then each scenario
  initial
  begin
    resetn = 1'b0;
    straps = PMS_MAX_DEV;                                 // highest legal address
    rd_data = 16'h0000;
    mismatches = 0;
    checks = 0;
    repeat (4) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (4) @(negedge clk_sys);
    write_cases();
    read_case();
    ignore_cases();
    close_out();
  end

  // hang guard
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    close_out();
  end
endmodule
